// [verilog/bbps_supervisor.sv]
// Top of the buck-boost protection supervisor: Wishbone registers, decode, timers, state.
// Assumes analog comparator flags arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
// What this block does
// - Decode limit scale: off, 150, 200, 150
// - At limit, regulate input current instead
// - Stop switching above 108 percent target
// - Over-voltage beyond 100 ms enters high impedance
// - Decode wire-drop compensation 0/100/200/300 mV
// - Light-load shutoff only while enable is one
// - Qualify: buck, headroom 0.5 V, below 6 V
// - Low current longer than delay declares light load
// - Light load: off state, output off, high impedance
// - Target writes ramp at selected slew rate
// - Step-down sink on while lowering until regulation
// - Over-voltage sink during over-voltage when enabled
// - State field reports live state codes
// - State reads zero outside powered mode
// - Switching frequency fixed, no user control
// - Output below 3 V: 3 s retry then reset
// - Input undervoltage: output off, reset state
module bbps_supervisor
    import bbps_pkg::*;
#(
    parameter int unsigned OV_PERSIST_CYC = OV_PERSIST_MS,     // ms of over-voltage
    parameter int unsigned RETRY_CYC      = RETRY_MS,          // ms of retry
    parameter int unsigned LL_UNIT_MS     = LL_DLY_S_UNIT * 1000, // ms per delay step
    parameter int unsigned MS_DIV         = CLK_PER_MS,        // clocks per ms
    parameter int unsigned SLEW_DIV0      = 1000               // clocks per ramp step, code 0
) (
    input  wire logic        clk_i,           // System clock
    input  wire logic        rst_i,           // Synchronous reset
    input  wire logic [31:0] wb_adr_i,        // Wishbone address
    input  wire logic [31:0] wb_dat_i,        // Wishbone write data
    input  wire logic [3:0]  wb_sel_i,        // Wishbone byte enables
    input  wire logic        wb_we_i,         // Wishbone write
    input  wire logic        wb_cyc_i,        // Wishbone cycle
    input  wire logic        wb_stb_i,        // Wishbone strobe
    output logic [31:0]      wb_dat_o,        // Wishbone read data
    output logic             wb_ack_o,        // Wishbone acknowledge
    input  wire logic        power_on_i,      // Powered operation mode request
    input  wire logic        in_lim_cmp_i,    // Input current at scaled limit
    input  wire logic        ov_cmp_i,        // Output above 108 percent target
    input  wire logic        buck_mode_i,     // Converter in buck mode
    input  wire logic        headroom_ok_i,   // Input exceeds output by 0.5 V
    input  wire logic        below_6v_i,      // Output below 6 V
    input  wire logic        low_curr_i,      // Output current below 5 mA
    input  wire logic        uv_out_i,        // Output below 3 V
    input  wire logic        uv_in_i,         // Input below minimum allowed
    input  wire logic        ss_done_i,       // Soft start finished
    input  wire logic        in_reg_i,        // Output in regulation
    output logic             switch_en_o,     // Power switches allowed
    output logic             in_reg_mode_o,   // Regulate input current
    output logic             high_impedance_mode_o, // High-impedance mode
    output logic [7:0]       limit_pct_o,     // Scaled limit percent, 0 is off
    output logic [8:0]       comp_mv_o,       // Wire-drop comp at reference load
    output logic [10:0]      setpoint_o,      // Ramped output set point
    output logic             step_sink_o,     // 70 mA step-down sink
    output logic             ov_sink_o,       // Over-voltage pulldown
    output logic [1:0]       fsw_sel_o        // Fixed switching frequency
);
    initial begin
        if (OV_PERSIST_CYC < 1 || RETRY_CYC < 1 || LL_UNIT_MS < 1 || SLEW_DIV0 < 1) begin
            $error("Timer parameters must be at least 1");
        end
    end
    // Two-flop synchronisers for analog flags
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign async_in = {power_on_i, in_lim_cmp_i, ov_cmp_i, buck_mode_i, headroom_ok_i,
                       below_6v_i, low_curr_i, uv_out_i, uv_in_i, ss_done_i, in_reg_i};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic pwr_s, lim_s, ov_s, buck_s, head_s, b6_s, low_s, uvo_s, uvi_s, ssd_s, reg_s;
    assign {pwr_s, lim_s, ov_s, buck_s, head_s, b6_s, low_s, uvo_s, uvi_s, ssd_s, reg_s}
        = sync2_reg;

    // Control registers
    logic [6:0]  ctrl_a_reg;
    logic [3:0]  ctrl_b_reg;
    logic [10:0] target_reg;
    logic        ll_en;
    logic [1:0]  ll_dly;
    logic [1:0]  slew_sel;
    logic        step_sink_en;
    logic        ov_sink_en;
    logic [1:0]  lim_scale;
    logic [1:0]  comp_sel;
    assign ll_en        = ctrl_a_reg[CA_LL_EN];
    assign ll_dly       = ctrl_a_reg[CA_LL_DLY +: 2];
    assign slew_sel     = ctrl_a_reg[CA_SLEW +: 2];
    assign step_sink_en = ctrl_a_reg[CA_STEP_SINK];
    assign ov_sink_en   = ctrl_a_reg[CA_OV_SINK];
    assign lim_scale    = ctrl_b_reg[CB_LIM_SCALE +: 2];
    assign comp_sel     = ctrl_b_reg[CB_COMP +: 2];

    // Wishbone slave: ack one cycle after strobe
    logic        wb_req;
    logic [31:0] rd_mux;
    bbps_state_e state_reg;
    logic        hiz_reg;
    logic [2:0]  state_field;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign state_field = pwr_s ? state_reg : ST_RESET;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_reg <= CTRL_A_RST;
            ctrl_b_reg <= CTRL_B_RST;
            target_reg <= VTARGET_RST;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i[7:0] == ADDR_CTRL_A && wb_sel_i[0]) ctrl_a_reg <= wb_dat_i[6:0];
            if (wb_adr_i[7:0] == ADDR_CTRL_B && wb_sel_i[0]) ctrl_b_reg <= wb_dat_i[3:0];
            if (wb_adr_i[7:0] == ADDR_VTARGET) begin
                if (wb_sel_i[0]) target_reg[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) target_reg[10:8] <= wb_dat_i[10:8];
            end
        end
    end
    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0;
        unique case (wb_adr_i[7:0])
            ADDR_CTRL_A:  rd_mux = {25'h0, ctrl_a_reg};
            ADDR_CTRL_B:  rd_mux = {28'h0, ctrl_b_reg};
            ADDR_VTARGET: rd_mux = {21'h0, target_reg};
            ADDR_STATUS:  rd_mux = {26'h0, hiz_reg, lim_s && lim_scale != 2'h0, ov_s,
                                    state_field};
            default:      rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req && !wb_we_i ? rd_mux : 32'h0;
        end
    end

    // Millisecond tick
    logic ms_tick;
    bbps_ms_tick #(.DIV(MS_DIV)) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (ms_tick)
    );

    // Over-voltage persistence timer in ms
    logic [31:0] ov_ms_reg;
    logic        ov_expired;
    assign ov_expired = ov_ms_reg > 32'(OV_PERSIST_CYC);
    always_ff @(posedge clk_i) begin
        if (rst_i || !ov_s || !pwr_s) begin
            ov_ms_reg <= 32'h0;
        end else if (ms_tick && !ov_expired) begin
            ov_ms_reg <= ov_ms_reg + 32'h1;
        end
    end

    // Light-load qualifier and timer
    logic        ll_qual;
    logic [31:0] ll_ms_reg;
    logic [31:0] ll_limit;
    logic        ll_hit;
    assign ll_qual  = ll_en && buck_s && head_s && b6_s && low_s;
    assign ll_limit = 32'(LL_UNIT_MS) * ((ll_dly == 2'h3) ? 32'h3 : 32'(ll_dly) + 32'h1);
    assign ll_hit   = ll_ms_reg > ll_limit;
    always_ff @(posedge clk_i) begin
        if (rst_i || !ll_qual || state_reg != ST_REG) begin
            ll_ms_reg <= 32'h0;
        end else if (ms_tick && !ll_hit) begin
            ll_ms_reg <= ll_ms_reg + 32'h1;
        end
    end

    // Retry timer in ms
    logic [31:0] retry_ms_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg != ST_RETRY) begin
            retry_ms_reg <= 32'h0;
        end else if (ms_tick) begin
            retry_ms_reg <= retry_ms_reg + 32'h1;
        end
    end

    // Power-on state machine; host toggles power to leave light-load off
    always_ff @(posedge clk_i) begin
        if (rst_i || !pwr_s) begin
            state_reg <= ST_RESET;
        end else if (uvi_s) begin
            state_reg <= ST_RESET;
        end else begin
            unique case (state_reg)
                ST_RESET:  state_reg <= hiz_reg ? ST_RESET : ST_SOFT;
                ST_SOFT:   state_reg <= uvo_s && ssd_s ? ST_RETRY : (ssd_s ? ST_REG : ST_SOFT);
                ST_REG: begin
                    if (uvo_s)       state_reg <= ST_RETRY;
                    else if (ll_hit) state_reg <= ST_LL_OFF;
                end
                ST_RETRY:  if (retry_ms_reg >= 32'(RETRY_CYC)) state_reg <= ST_RESET;
                ST_LL_OFF: state_reg <= ST_LL_OFF;
                default:   state_reg <= ST_RESET;
            endcase
        end
    end
    // High-impedance mode, cleared only by leaving powered mode
    always_ff @(posedge clk_i) begin
        if (rst_i || !pwr_s) begin
            hiz_reg <= 1'b0;
        end else if (ov_expired || (state_reg == ST_REG && ll_hit && !uvo_s)) begin
            hiz_reg <= 1'b1;
        end
    end

    // Ramp step enable from slew select
    logic [31:0] slew_cnt_reg;
    logic [31:0] slew_div;
    logic        slew_step;
    assign slew_div  = 32'(SLEW_DIV0) << slew_sel;
    assign slew_step = slew_cnt_reg >= slew_div - 32'h1;
    always_ff @(posedge clk_i) begin
        if (rst_i || slew_step) begin
            slew_cnt_reg <= 32'h0;
        end else begin
            slew_cnt_reg <= slew_cnt_reg + 32'h1;
        end
    end
    logic [10:0] ramp;
    logic        ramp_down;
    bbps_slew u_slew (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .step_i   (slew_step),
        .target_i (target_reg),
        .ramp_o   (ramp),
        .down_o   (ramp_down)
    );

    // Step-down sink latch: on when lowering, off at regulation
    logic sink_on_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !step_sink_en) begin
            sink_on_reg <= 1'b0;
        end else if (ramp_down) begin
            sink_on_reg <= 1'b1;
        end else if (reg_s) begin
            sink_on_reg <= 1'b0;
        end
    end

    // Registered outputs
    logic running;
    assign running = pwr_s && !hiz_reg && !uvi_s &&
                     (state_reg == ST_SOFT || state_reg == ST_REG);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_en_o           <= 1'b0;
            in_reg_mode_o         <= 1'b0;
            high_impedance_mode_o <= 1'b0;
            limit_pct_o           <= 8'h00;
            comp_mv_o             <= 9'h000;
            setpoint_o            <= VTARGET_RST;
            step_sink_o           <= 1'b0;
            ov_sink_o             <= 1'b0;
            fsw_sel_o             <= FSW_500K;
        end else begin
            switch_en_o           <= running && !ov_s;
            in_reg_mode_o         <= lim_s && lim_scale != 2'h0;
            high_impedance_mode_o <= hiz_reg;
            limit_pct_o           <= (lim_scale == 2'h0) ? 8'h00 :
                                     (lim_scale == 2'h2) ? SCALE_200 : SCALE_150;
            comp_mv_o             <= 9'(COMP_MV_STEP * comp_sel);
            setpoint_o            <= ramp;
            step_sink_o           <= sink_on_reg && running;
            ov_sink_o             <= ov_sink_en && ov_s;
            fsw_sel_o             <= FSW_500K;
        end
    end

    // Checks
    a_ov_stops_switch: assert property (@(posedge clk_i) disable iff (rst_i)
        ov_s |=> !switch_en_o) else $error("switching during over-voltage");
    a_ov_sink_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ov_s && ov_sink_en |=> ov_sink_o) else $error("ov sink not active");
    a_limit_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(lim_scale) && lim_scale == 2'h3 |=> limit_pct_o == 8'd150)
        else $error("limit code 11 not 150");
    a_state_off_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !pwr_s |-> state_field == 3'b000) else $error("state nonzero outside power");
    a_state_legal: assert property (@(posedge clk_i) disable iff (rst_i)
        state_field <= 3'b100) else $error("illegal state code");
    a_uv_in_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        pwr_s && uvi_s |=> state_reg == ST_RESET) else $error("undervoltage not reset");
    sequence s_reg_uv;
        state_reg == ST_REG && pwr_s && !uvi_s && uvo_s;
    endsequence
    a_retry_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg_uv |=> state_reg == ST_RETRY) else $error("no retry on output fault");
    a_ll_off_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_LL_OFF && pwr_s |-> hiz_reg ##1 !switch_en_o)
        else $error("light-load off not high impedance");
    a_ll_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
        !ll_en |=> ll_ms_reg == 32'h0) else $error("light-load timer while disabled");
    a_ov_to_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        pwr_s && ov_expired |=> hiz_reg) else $error("over-voltage timeout missed");
    a_hiz_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        hiz_reg && pwr_s |=> hiz_reg) else $error("high impedance left while powered");
    // Ramp moves only on a step, one code at a time
    sequence s_ramp_up;
        slew_step && ramp < target_reg;
    endsequence
    a_ramp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !slew_step |=> $stable(ramp)) else $error("ramp moved without step");
    a_ramp_up: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ramp_up |=> ramp == $past(ramp) + 11'h001) else $error("ramp step not one code");
    // Sink release and decode checks
    a_sink_release: assert property (@(posedge clk_i) disable iff (rst_i)
        !ramp_down && reg_s |=> !sink_on_reg) else $error("step sink held in regulation");
    a_comp_off: assert property (@(posedge clk_i) disable iff (rst_i)
        comp_sel == 2'h0 |=> comp_mv_o == 9'h000) else $error("compensation not off");
    a_scale_off: assert property (@(posedge clk_i) disable iff (rst_i)
        lim_scale == 2'h0 |=> !in_reg_mode_o) else $error("input regulation while off");
    a_fsw_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
        fsw_sel_o == FSW_500K) else $error("switching frequency changed");
endmodule : bbps_supervisor

// [shared/bbps_pkg.sv]
// Package for the buck-boost protection supervisor: register map, fields, states, timings.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
package bbps_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL_A     = 8'h38;  // Light-load and slew controls
    localparam logic [7:0]  ADDR_CTRL_B     = 8'h3C;  // Limit scale and wire-drop comp
    localparam logic [7:0]  ADDR_VTARGET    = 8'h40;  // Output voltage target
    localparam logic [7:0]  ADDR_STATUS     = 8'h80;  // Live state and flags
    // Field positions in control A
    localparam int unsigned CA_LL_EN        = 0;
    localparam int unsigned CA_LL_DLY       = 1;
    localparam int unsigned CA_SLEW         = 3;
    localparam int unsigned CA_STEP_SINK    = 5;
    localparam int unsigned CA_OV_SINK      = 6;
    // Field positions in control B
    localparam int unsigned CB_LIM_SCALE    = 0;
    localparam int unsigned CB_COMP         = 2;
    // Field positions in status
    localparam int unsigned ST_STATE        = 0;
    localparam int unsigned ST_OV           = 3;
    localparam int unsigned ST_IN_LIM       = 4;
    localparam int unsigned ST_HIZ          = 5;
    // Reset values
    localparam logic [6:0]  CTRL_A_RST      = 7'h00;
    localparam logic [3:0]  CTRL_B_RST      = 4'h0;
    localparam logic [10:0] VTARGET_RST     = 11'h000;
    // Timings in their own unit
    localparam int unsigned OV_PERSIST_MS   = 100;
    localparam int unsigned RETRY_MS        = 3000;
    localparam int unsigned LL_DLY_S_UNIT   = 10;
    // Scale percentages, in percent of resistor-set limit
    localparam logic [7:0]  SCALE_150       = 8'd150;
    localparam logic [7:0]  SCALE_200       = 8'd200;
    // Compensation values in millivolts
    localparam logic [8:0]  COMP_MV_STEP    = 9'd100;
    // Output switching frequency select, factory fixed: 500 kHz
    localparam logic [1:0]  FSW_500K        = 2'h2;
    // Power-on state machine codes
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_SOFT   = 3'b001,
        ST_REG    = 3'b010,
        ST_RETRY  = 3'b011,
        ST_LL_OFF = 3'b100
    } bbps_state_e;
endpackage : bbps_pkg

// [verilog/bbps_ms_tick.sv]
// Millisecond tick divider.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
module bbps_ms_tick
    import bbps_pkg::*;
#(
    parameter int unsigned DIV = CLK_PER_MS
) (
    input  wire logic clk_i,   // System clock
    input  wire logic rst_i,   // Synchronous reset
    output logic      tick_o   // One-cycle pulse per period
);
    initial begin
        if (DIV < 2) $error("DIV must be at least 2");
    end
    logic [31:0] cnt_reg;
    // Count up the period and pulse at wrap
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_reg == 32'(DIV - 1)) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_reg == 32'(DIV - 1));
        end
    end
endmodule : bbps_ms_tick

// [verilog/bbps_slew.sv]
// Output set-point ramp generator, one LSB per slew step.
// Assumes step enable comes from the same clock domain.
`timescale 1ns/1ps
module bbps_slew
    import bbps_pkg::*;
(
    input  wire logic        clk_i,     // System clock
    input  wire logic        rst_i,     // Synchronous reset
    input  wire logic        step_i,    // Ramp step enable
    input  wire logic [10:0] target_i,  // Programmed target
    output logic [10:0]      ramp_o,    // Present ramped set point
    output logic             down_o     // Ramp moving downward
);
    // Walk ramp one code toward target per step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_o <= VTARGET_RST;
        end else if (step_i && ramp_o < target_i) begin
            ramp_o <= ramp_o + 11'h001;
        end else if (step_i && ramp_o > target_i) begin
            ramp_o <= ramp_o - 11'h001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            down_o <= 1'b0;
        end else begin
            down_o <= (ramp_o > target_i);
        end
    end
endmodule : bbps_slew

// [test/bbps_stage_model.sv]
// Analog stage model: soft start completion and regulation flag.
// Assumes the supervisor's clock, switch enable and set point.
`timescale 1ns/1ps
module bbps_stage_model (
    input  wire logic        clk_i,       // System clock
    input  wire logic        switch_en_i, // Switching allowed
    input  wire logic [10:0] setpoint_i,  // Ramped set point
    output logic             ss_done_o,   // Soft start finished
    output logic             in_reg_o     // Output in regulation
);
    logic [3:0]  run_reg;
    logic [10:0] vout_reg;
    // Soft start needs nine clocks of switching; output trails set point
    always_ff @(posedge clk_i) begin
        run_reg  <= switch_en_i ? run_reg + 4'(run_reg != 4'hF) : 4'h0;
        vout_reg <= setpoint_i;
    end
    // Regulated only while switching and settled
    assign ss_done_o = run_reg > 4'h8;
    assign in_reg_o  = switch_en_i && vout_reg == setpoint_i;
endmodule : bbps_stage_model

// [test/bbps_supervisor_test.sv]
// Self-checking bench for the protection supervisor.
// Assumes short timers: 4 clocks per ms, 3 ms per light-load step.
`timescale 1ns/1ps
module bbps_supervisor_test;
    import bbps_pkg::*;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
    logic [3:0]  wb_sel_i;
    logic        power_on_i, in_lim_cmp_i, ov_cmp_i, buck_mode_i, headroom_ok_i;
    logic        below_6v_i, low_curr_i, uv_out_i, uv_in_i, ss_done_i, in_reg_i;
    logic        switch_en_o, in_reg_mode_o, high_impedance_mode_o, step_sink_o, ov_sink_o;
    logic [7:0]  limit_pct_o;
    logic [8:0]  comp_mv_o;
    logic [10:0] setpoint_o, tgt;
    logic [1:0]  fsw_sel_o;
    int          n_errors, n_tests, t0, c;
    // Design with shortened timers
    bbps_supervisor #(.OV_PERSIST_CYC(2), .RETRY_CYC(3), .LL_UNIT_MS(3), .MS_DIV(4),
        .SLEW_DIV0(1)) i_bbps_supervisor (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .power_on_i, .in_lim_cmp_i,
        .ov_cmp_i, .buck_mode_i, .headroom_ok_i, .below_6v_i, .low_curr_i, .uv_out_i,
        .uv_in_i, .ss_done_i, .in_reg_i, .switch_en_o, .in_reg_mode_o,
        .high_impedance_mode_o, .limit_pct_o, .comp_mv_o, .setpoint_o, .step_sink_o,
        .ov_sink_o, .fsw_sel_o);
    // Analog stage answering soft start and regulation
    bbps_stage_model i_bbps_stage_model (.clk_i, .switch_en_i(switch_en_o),
        .setpoint_i(setpoint_o), .ss_done_o(ss_done_i), .in_reg_o(in_reg_i));
    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Verdict and end of run
    task automatic test_done;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic tmo;
        n_errors++;
        $display("MISMATCH %0t timeout", $time);
        test_done;
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk
    // Classic Wishbone single cycle, waits for ack under a bound
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
        int i;
        @(posedge clk_i);
        {wb_adr_i, wb_dat_i} <= {32'(a), d};
        {wb_we_i, wb_sel_i, wb_cyc_i, wb_stb_i} <= {w, 4'hF, 2'h3};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (wb_ack_o !== 1'b1) tmo;
    endtask : wb
    // Poll the state field until it shows the wanted code
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 100; i++) begin
            wb(ADDR_STATUS, 1'b0, 32'h0, q);
            if (q[2:0] === s) break;
        end
        chk(q[2:0], s, "state");
    endtask : wait_state
    task automatic wait_sp(input logic [10:0] t);
        for (int i = 0; i < 4000 && setpoint_o !== t; i++) @(posedge clk_i);
        chk(setpoint_o, t, "set point");
    endtask : wait_sp
    // Expected limit percent and light-load delay in clocks
    function automatic logic [7:0] pct(input int s);
        return s == 0 ? 8'h00 : (s == 2 ? 8'hC8 : 8'h96);
    endfunction : pct
    function automatic int ll_cyc(input int d);
        return 12 * ((d > 2 ? 2 : d) + 1);
    endfunction : ll_cyc
    // Main sequence
    initial begin
        c = $urandom(32'hB345);
        {n_errors, n_tests, rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = {64'h0, 4'h8};
        {wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
        {power_on_i, in_lim_cmp_i, ov_cmp_i, buck_mode_i, headroom_ok_i} = 5'h0;
        {below_6v_i, low_curr_i, uv_out_i, uv_in_i} = 4'h0;
        tk(2);
        rst_i <= 1'b0;
        wb(ADDR_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h0, "status reset");
        chk(fsw_sel_o, FSW_500K, "fsw");
        wb(8'hFC, 1'b1, 32'hFFFF_FFFF, q);
        wb(8'hFC, 1'b0, 32'h0, q);
        chk(q, 32'h0, "unmapped");
        // Every limit scale code with a random compensation code
        for (int i = 0; i < 4; i++) begin
            c = $urandom % 4;
            wb(ADDR_CTRL_B, 1'b1, 32'(c * 4 + i), q);
            tk(2);
            chk(limit_pct_o, pct(i), "limit scale");
            chk(comp_mv_o, 32'(100 * c), "wire drop");
        end
        in_lim_cmp_i <= 1'b1;
        wb(ADDR_CTRL_B, 1'b1, 32'h1, q);
        tk(4);
        chk(in_reg_mode_o, 1'b1, "in limit on");
        wb(ADDR_CTRL_B, 1'b1, 32'h0, q);
        tk(4);
        chk(in_reg_mode_o, 1'b0, "in limit off");
        in_lim_cmp_i <= 1'b0;
        power_on_i <= 1'b1;
        wait_state(ST_REG);
        // Ramp at two clocks per step, then step down with the sink
        tgt = 11'($urandom % 1024 + 512);
        wb(ADDR_CTRL_A, 1'b1, 32'h8, q);
        t0 = $time;
        wb(ADDR_VTARGET, 1'b1, 32'(tgt), q);
        wait_sp(tgt);
        c = ($time - t0) / 10;
        chk(c >= 2 * tgt && c <= 2 * tgt + 12, 1'b1, "slew");
        wb(ADDR_VTARGET, 1'b0, 32'h0, q);
        chk(q, 32'(tgt), "target read");
        wb(ADDR_CTRL_A, 1'b1, 32'h20, q);
        wb(ADDR_VTARGET, 1'b1, 32'(tgt - 11'h100), q);
        tk(3);
        chk(step_sink_o, 1'b1, "sink on");
        wait_sp(tgt - 11'h100);
        tk(6);
        chk(step_sink_o, 1'b0, "sink off");
        // Output undervoltage retries, input undervoltage resets
        uv_out_i <= 1'b1;
        wait_state(ST_RETRY);
        uv_out_i <= 1'b0;
        wait_state(ST_REG);
        uv_in_i <= 1'b1;
        tk(4);
        chk(switch_en_o, 1'b0, "uv in");
        wait_state(ST_RESET);
        uv_in_i <= 1'b0;
        wait_state(ST_REG);
        // Light load qualified while the function is disabled
        {buck_mode_i, headroom_ok_i, below_6v_i, low_curr_i} <= 4'hF;
        tk(200);
        wait_state(ST_REG);
        // Every delay code, then restart by toggling power
        for (int i = 0; i < 4; i++) begin
            wb(ADDR_CTRL_A, 1'b1, 32'(i * 2 + 1), q);
            t0 = $time;
            wait_state(ST_LL_OFF);
            c = ($time - t0) / 10;
            chk(c > ll_cyc(i) && c < ll_cyc(i) + 28, 1'b1, "delay");
            chk({high_impedance_mode_o, switch_en_o}, 2'b10, "ll off");
            wb(ADDR_CTRL_A, 1'b1, 32'h0, q);
            power_on_i <= 1'b0;
            tk(4);
            wait_state(ST_RESET);
            power_on_i <= 1'b1;
            wait_state(ST_REG);
        end
        // Over-voltage stops switching, sinks, then goes high impedance
        low_curr_i <= 1'b0;
        wb(ADDR_CTRL_A, 1'b1, 32'h40, q);
        ov_cmp_i <= 1'b1;
        t0 = $time;
        tk(4);
        chk({switch_en_o, ov_sink_o, high_impedance_mode_o}, 3'b010, "ov");
        for (int i = 0; i < 60 && high_impedance_mode_o !== 1'b1; i++) @(posedge clk_i);
        c = ($time - t0) / 10;
        chk(c > 8 && high_impedance_mode_o === 1'b1, 1'b1, "ov persist");
        wb(ADDR_STATUS, 1'b0, 32'h0, q);
        chk(q[5:3], 3'b101, "ov status");
        ov_cmp_i <= 1'b0;
        tk(4);
        chk(ov_sink_o, 1'b0, "ov sink off");
        test_done;
    end
endmodule : bbps_supervisor_test
